// File: core/cond_eval.sv
// Condition evaluator: a four-entry lookup of the condition field
// indexed by the carry and zero flags.
// Assumes flags and field are stable, same-clock signals.
`timescale 1ns/1ps
module cond_eval (
  input wire logic [3:0] condition_field,
  input wire logic carry,
  input wire logic zero,
  output logic execute
);

  // One product term per table entry
  logic [3:0] hit;

  // Entry k fires when {carry,zero} equals k and its bit is set
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_entry
      assign hit[k] = condition_field[k] & ({carry, zero} == 2'(k));
    end
  endgenerate

  // Any entry hit enables execution
  assign execute = |hit;

endmodule // cond_eval

// File: core/cond_exec_and_hub_op_decode.sv
// Conditional execution sequencer and shared resource operation issue.
// Assumes the register file supplies dest_value and src_value for the
// instruction offered, and the ALU supplies its result and flags in the
// same cycle; the hub arbiter is same-clock logic.
`timescale 1ns/1ps
`include "cond_exec_cfg.svh"

// Summary of operation
// - Execute only when selected flag condition holds
// - False condition: four-cycle no-op, nothing changes
// - Code 1111 always, 0000 never executes
// - 1010 needs zero set, 0101 zero clear
// - 1100 needs carry set, 0011 carry clear
// - 1001 flags equal, 0110 flags differ
// - AND codes 1000, 0100, 0010, 0001
// - OR codes 1110, 1101, 1011, 0111
// - Carry kept unless update requested
// - Hub form decoded by opcode 000011
// - Three-bit selector from source, register or immediate
// - Destination register contents sent as operand
// - Hub result unwritten by default; zero flag
// - Hub instruction takes 7 to 22 cycles
// - All hub operations share one form
// - Update controls follow effect bits field
module cond_exec_and_hub_op_decode #(
  parameter int exec_cycles = `CE_EXEC_CYCLES,
  parameter int hub_min = `CE_HUB_MIN,
  parameter int hub_max = `CE_HUB_MAX
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] dest_value,
  input wire logic [31:0] src_value,
  input wire logic [31:0] alu_result,
  input wire logic alu_carry,
  input wire logic alu_zero,
  input wire logic hub_window,
  input wire logic [31:0] hub_result,
  input wire logic hub_carry,
  output logic ready,
  output logic done,
  output logic executed,
  output logic carry_flag,
  output logic zero_flag,
  output logic write_en,
  output logic [8:0] write_addr,
  output logic [31:0] write_data,
  output logic hub_req,
  output logic [2:0] hub_sel,
  output logic [31:0] hub_operand
);

  // Refuse counts the five-bit counter cannot hold
  if (exec_cycles < 2 || exec_cycles > 31 || hub_min < 2 || hub_max < hub_min || hub_max > 31) begin : g_bad
    $error("cond_exec: cycle counts out of range");
  end

  // Field views of the offered instruction
  logic [3:0] cond;
  logic is_hub;
  logic cond_ok;
  logic accept;
  logic [2:0] sel_src;

  assign cond = instr_word[`CE_COND_HI:`CE_COND_LO];
  assign is_hub = instr_word[`CE_OPC_HI:`CE_OPC_LO] == `CE_OPC_HUB;
  assign accept = instr_valid & ready;
  // Immediate selector from the source field, else the named register
  assign sel_src = instr_word[`CE_EFF_I] ? instr_word[2:0] : src_value[2:0];

  // Condition against the flags as left by the previous instruction
  cond_eval u_cond (
    .condition_field(cond),
    .carry(carry_flag),
    .zero(zero_flag),
    .execute(cond_ok)
  );

  // Sequencer and latched instruction state
  cond_exec_pkg::seq_state_t state, next_state;
  logic [4:0] cnt, next_cnt; // Cycles since accept
  logic z_req, next_z_req; // Latched effect bits
  logic c_req, next_c_req;
  logic r_req, next_r_req;
  logic hub_last, next_hub_last; // Current instruction is a hub form
  logic win_seen, next_win_seen; // Hub access window granted
  logic [31:0] res, next_res; // Pending result
  logic res_c, next_res_c; // Pending carry
  logic res_z, next_res_z; // Pending zero
  logic next_ready, next_done, next_executed;
  logic next_carry, next_zero, next_write_en;
  logic [8:0] next_write_addr;
  logic [31:0] next_write_data;
  logic next_hub_req;
  logic [2:0] next_hub_sel;
  logic [31:0] next_hub_operand;
  logic finish;

  // Next-value logic of the whole sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_z_req = z_req;
    next_c_req = c_req;
    next_r_req = r_req;
    next_hub_last = hub_last;
    next_win_seen = win_seen;
    next_res = res;
    next_res_c = res_c;
    next_res_z = res_z;
    next_ready = ready;
    next_done = 1'b0;
    next_executed = executed;
    next_carry = carry_flag;
    next_zero = zero_flag;
    next_write_en = 1'b0;
    next_write_addr = write_addr;
    next_write_data = write_data;
    next_hub_req = hub_req;
    next_hub_sel = hub_sel;
    next_hub_operand = hub_operand;
    finish = 1'b0;
    case (state)
      cond_exec_pkg::st_idle: begin
        // Take an instruction and capture its controls
        if (accept) begin
          next_ready = 1'b0;
          next_cnt = 5'h01;
          next_z_req = instr_word[`CE_EFF_Z];
          next_c_req = instr_word[`CE_EFF_C];
          next_r_req = instr_word[`CE_EFF_R];
          next_hub_last = is_hub;
          next_win_seen = 1'b0;
          next_write_addr = instr_word[`CE_DEST_HI:`CE_DEST_LO];
          next_res = alu_result;
          next_res_c = alu_carry;
          next_res_z = alu_zero;
          if (!cond_ok) begin
            next_state = cond_exec_pkg::st_skip;
          end else if (is_hub) begin
            next_state = cond_exec_pkg::st_hub;
            next_hub_req = 1'b1;
            next_hub_sel = sel_src;
            next_hub_operand = dest_value;
          end else begin
            next_state = cond_exec_pkg::st_run;
          end
        end
      end
      cond_exec_pkg::st_run: begin
        // Executed ordinary instruction: fixed length
        next_cnt = cnt + 5'h01;
        if (cnt == 5'(exec_cycles - 1)) begin
          finish = 1'b1;
          next_executed = 1'b1;
        end
      end
      cond_exec_pkg::st_skip: begin
        // Condition false: same length, no effect
        next_cnt = cnt + 5'h01;
        if (cnt == `CE_NOP_CYCLES - 5'h01) begin
          finish = 1'b1;
          next_executed = 1'b0;
        end
      end
      cond_exec_pkg::st_hub: begin
        // Wait for the access window, then for the least length
        next_cnt = cnt + 5'h01;
        if (hub_window && !win_seen) begin
          next_win_seen = 1'b1;
          next_hub_req = 1'b0;
          next_res = hub_result;
          next_res_c = hub_carry;
          next_res_z = hub_result == 32'h0000_0000;
        end
        if (((win_seen || hub_window) && cnt >= 5'(hub_min - 1)) || cnt == 5'(hub_max - 1)) begin
          finish = 1'b1;
          next_executed = 1'b1;
          next_hub_req = 1'b0;
        end
      end
      default: begin
        next_state = cond_exec_pkg::st_idle;
        next_ready = 1'b1;
      end
    endcase
    // Completion: flags and result written only when executed
    if (finish) begin
      next_state = cond_exec_pkg::st_idle;
      next_ready = 1'b1;
      next_done = 1'b1;
      next_write_data = next_res;
      if (next_executed) begin
        if (c_req) begin
          next_carry = next_res_c;
        end
        if (z_req) begin
          next_zero = next_res_z;
        end
        next_write_en = r_req;
      end
    end
  end

  // Registers of the sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= cond_exec_pkg::st_idle;
      cnt <= 5'h00;
      z_req <= 1'b0;
      c_req <= 1'b0;
      r_req <= 1'b0;
      hub_last <= 1'b0;
      win_seen <= 1'b0;
      res <= 32'h0000_0000;
      res_c <= 1'b0;
      res_z <= 1'b0;
      ready <= 1'b1;
      done <= 1'b0;
      executed <= 1'b0;
      carry_flag <= `CE_CARRY_RST;
      zero_flag <= `CE_ZERO_RST;
      write_en <= 1'b0;
      write_addr <= 9'h000;
      write_data <= 32'h0000_0000;
      hub_req <= 1'b0;
      hub_sel <= 3'h0;
      hub_operand <= 32'h0000_0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      z_req <= next_z_req;
      c_req <= next_c_req;
      r_req <= next_r_req;
      hub_last <= next_hub_last;
      win_seen <= next_win_seen;
      res <= next_res;
      res_c <= next_res_c;
      res_z <= next_res_z;
      ready <= next_ready;
      done <= next_done;
      executed <= next_executed;
      carry_flag <= next_carry;
      zero_flag <= next_zero;
      write_en <= next_write_en;
      write_addr <= next_write_addr;
      write_data <= next_write_data;
      hub_req <= next_hub_req;
      hub_sel <= next_hub_sel;
      hub_operand <= next_hub_operand;
    end
  end

  // Checker helpers: age of the instruction in flight and its effect bits
  logic [5:0] age;
  logic last_c, last_z;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      age <= 6'h00;
      last_c <= 1'b0;
      last_z <= 1'b0;
    end else if (accept) begin
      age <= 6'h01;
      last_c <= instr_word[`CE_EFF_C];
      last_z <= instr_word[`CE_EFF_Z];
    end else if (age != 6'h3F) begin
      age <= age + 6'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_false_nop: assert property (accept && !cond_ok |=> !done [*3] ##1 (done && !executed))
    else $error("false condition did not end as four-cycle no-op");
  chk_nop_quiet: assert property (done && !executed |-> $stable(carry_flag) && $stable(zero_flag) && !write_en)
    else $error("skipped instruction changed state");
  chk_always_runs: assert property (accept && cond == `CE_COND_ALWAYS && !is_hub |=> ##3 (done && executed))
    else $error("always condition did not execute");
  chk_never_runs: assert property (accept && cond == `CE_COND_NEVER |=> ##3 (done && !executed))
    else $error("never condition executed");
  chk_cond_lookup: assert property (accept |->
    cond_ok == (carry_flag ? (zero_flag ? cond[3] : cond[2]) : (zero_flag ? cond[1] : cond[0])))
    else $error("condition lookup mismatch");
  chk_carry_hold: assert property (done && !(executed && last_c) |-> $stable(carry_flag))
    else $error("carry changed without request");
  chk_hub_stall: assert property (done && hub_last && executed |-> age >= 6'(hub_min) && age <= 6'(hub_max))
    else $error("hub instruction length outside 7 to 22");
  chk_hub_issue: assert property (accept && is_hub && cond_ok |=> hub_req && hub_operand == $past(dest_value) && hub_sel == $past(sel_src))
    else $error("hub operand or selector wrong");
  chk_hub_zero: assert property (done && executed && hub_last && last_z |-> zero_flag == (write_data == 32'h0000_0000))
    else $error("hub zero flag wrong");
  cov_skip: cover property (accept && !cond_ok);
  cov_hub_done: cover property (done && hub_last && executed);
  cov_back_to_back: cover property (done && ready && instr_valid);
endmodule // cond_exec_and_hub_op_decode

// File: shared/cond_exec_cfg.svh
// Constants of the condition and hub-operation decoder: field positions,
// opcodes, cycle counts and reset values.
// Assumes a 32-bit instruction word and a 125 MHz core clock.
`ifndef COND_EXEC_CFG_SVH
`define COND_EXEC_CFG_SVH

// Instruction word fields
`define CE_OPC_HI 31
`define CE_OPC_LO 26
`define CE_EFF_Z 25
`define CE_EFF_C 24
`define CE_EFF_R 23
`define CE_EFF_I 22
`define CE_COND_HI 21
`define CE_COND_LO 18
`define CE_DEST_HI 17
`define CE_DEST_LO 9
`define CE_SRC_HI 8
`define CE_SRC_LO 0

// Opcode of the shared resource operation form
`define CE_OPC_HUB 6'h03
// Condition codes with fixed meaning
`define CE_COND_ALWAYS 4'hF
`define CE_COND_NEVER 4'h0

// Cycle counts, whole instruction including the accept cycle
`define CE_EXEC_CYCLES 5'h04
`define CE_NOP_CYCLES 5'h04
`define CE_HUB_MIN 5'h07
`define CE_HUB_MAX 5'h16

// Reset values of the flags
`define CE_CARRY_RST 1'h0
`define CE_ZERO_RST 1'h0

`endif

// File: shared/cond_exec_pkg.sv
// Types of the condition and hub-operation decoder.
// Assumes the constants of cond_exec_cfg.svh for widths and codes.
package cond_exec_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_run  = 4'h2,
    st_skip = 4'h4,
    st_hub  = 4'h8
  } seq_state_t;

  // Hub operation selector values
  typedef enum logic [2:0] {
    clock_config_write  = 3'h0,
    core_identity_query = 3'h1,
    core_launch         = 3'h2,
    core_halt           = 3'h3,
    semaphore_allocate  = 3'h4,
    semaphore_release   = 3'h5,
    semaphore_acquire   = 3'h6,
    semaphore_clear     = 3'h7
  } hub_sel_t;

endpackage

// File: tb/hub_arbiter_model.sv
// Behavioural model of the shared hub arbiter with one rotating window slot.
// Assumes the same ref_clk as the decoder and a request level held until served.
`timescale 1ns/1ps
module hub_arbiter_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hub_req,
  input wire logic [2:0] hub_sel,
  input wire logic [31:0] hub_operand,
  input wire logic [3:0] phase,
  input wire logic stall,
  output logic hub_window,
  output logic hub_result,
  output logic [31:0] hub_data,
  output logic hub_carry
);
  logic [3:0] slot_cnt; // Free-running slot position, one window every 16 clocks
  logic grant; // Window is due in the coming cycle
  // Grant only in our slot and only while a request stands
  always_comb grant = hub_req && (slot_cnt == phase) && !stall;
  // Outside a window the result lines toggle so stale data never looks valid
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slot_cnt <= 4'h0;
      hub_window <= 1'b0;
      hub_data <= 32'h0;
      hub_carry <= 1'b0;
    end else begin
      slot_cnt <= slot_cnt + 4'h1;
      hub_window <= grant;
      hub_data <= grant ? (hub_operand ^ {29'h0, hub_sel}) : ~hub_data;
      hub_carry <= grant ? ^hub_operand : ~hub_carry;
    end
  end
  assign hub_result = hub_window;
endmodule // hub_arbiter_model

// File: tb/tb_top.sv
// Self-checking bench of the condition and hub-operation decoder.
// Assumes the hub arbiter model at the far side; inputs change on falling edges.
`timescale 1ns/1ps
`include "cond_exec_cfg.svh"
module tb_top;
  logic ref_clk, rst, instr_valid, alu_carry, alu_zero, hub_window, hub_carry, stall;
  logic [31:0] instr_word, dest_value, src_value, alu_result, hub_result;
  logic ready, done, executed, carry_flag, zero_flag, write_en, hub_req;
  logic [8:0] write_addr;
  logic [31:0] write_data, hub_operand;
  logic [2:0] hub_sel;
  logic [3:0] phase;
  int fail_count, comparisons, cc, f, s;
  integer seed; // Seed of the random stimulus
  int cf, zf; // Reference flags
  // The design under test
  cond_exec_and_hub_op_decode DUT (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .dest_value(dest_value), .src_value(src_value), .alu_result(alu_result),
    .alu_carry(alu_carry), .alu_zero(alu_zero), .hub_window(hub_window), .hub_result(hub_result),
    .hub_carry(hub_carry), .ready(ready), .done(done), .executed(executed), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .write_en(write_en), .write_addr(write_addr), .write_data(write_data),
    .hub_req(hub_req), .hub_sel(hub_sel), .hub_operand(hub_operand));
  // Far side of the hub interface
  hub_arbiter_model hub (.ref_clk(ref_clk), .rst(rst), .hub_req(hub_req), .hub_sel(hub_sel),
    .hub_operand(hub_operand), .phase(phase), .stall(stall), .hub_window(hub_window),
    .hub_result(), .hub_data(hub_result), .hub_carry(hub_carry));
  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One comparison
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask
  // Issue one instruction and check it against the reference
  task automatic run(input logic [31:0] w, input logic ac, input logic az, input logic zh);
    logic ex, hb;
    logic [2:0] sel;
    logic [31:0] hres;
    int e, k, n;
    @(negedge ref_clk);
    chk("ready", 1, ready);
    chk("done_pulse", 0, done);
    instr_word = w;
    src_value = $random(seed);
    alu_result = $random(seed);
    alu_carry = ac;
    alu_zero = az;
    sel = w[`CE_EFF_I] ? w[2:0] : src_value[2:0];
    dest_value = zh ? {29'h0, sel} : $random(seed);
    ex = w[`CE_COND_LO + 2 * cf + zf];
    hb = ex && (w[31:26] == `CE_OPC_HUB);
    hres = dest_value ^ {29'h0, sel};
    instr_valid = 1'b1;
    @(posedge ref_clk);
    e = 0;
    k = 0;
    while (e < 30) begin
      @(negedge ref_clk);
      instr_valid = 1'b0;
      if (e == 0) begin
        chk("hub_req", hb, hub_req);
        if (hb) chk("hub_sel", sel, hub_sel);
        if (hb) chk("hub_operand", dest_value, hub_operand);
      end
      if (hub_window === 1'b1 && k == 0) k = e + 1;
      if (done === 1'b1) break;
      @(posedge ref_clk);
      e++;
    end
    if (e >= 30) begin
      fail_count++;
      results();
    end
    n = !hb ? 4 : (k == 0 ? 22 : (k + 1 < 7 ? 7 : k + 1));
    chk("cycles", n, e + 1);
    chk("executed", ex, executed);
    if (ex && w[`CE_EFF_C]) cf = hb ? ^dest_value : ac;
    if (ex && w[`CE_EFF_Z]) zf = hb ? (hres == 0) : az;
    chk("carry_flag", cf, carry_flag);
    chk("zero_flag", zf, zero_flag);
    chk("write_en", ex && w[`CE_EFF_R], write_en);
    if (ex && w[`CE_EFF_R]) chk("write_data", hb ? hres : alu_result, write_data);
    if (ex) chk("write_addr", w[17:9], write_addr);
  endtask
  // Main sequence
  initial begin
    seed = 32'hDB9C;
    fail_count = 0;
    comparisons = 0;
    cf = 0;
    zf = 0;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 32'h0;
    dest_value = 32'h0;
    src_value = 32'h0;
    alu_result = 32'h0;
    alu_carry = 1'b0;
    alu_zero = 1'b0;
    phase = 4'h0;
    stall = 1'b0;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    chk("reset_flags", 0, {carry_flag, zero_flag, hub_req, write_en, done});
    // Every condition code against every flag pair, own updates random
    for (cc = 0; cc < 16; cc++) begin
      for (f = 0; f < 4; f++) begin
        run({6'h21, 4'hC | 4'($random(seed)), 4'hF, 18'($random(seed))}, f[1], f[0], 1'b0);
        run({6'h10 + 6'(cc % 8), 4'($random(seed)) & 4'hE, 4'(cc), 18'($random(seed))}, 1'($random(seed)),
          1'($random(seed)), 1'b0);
      end
    end
    // Every hub selector as immediate, then register-sourced random selectors, at random window phases
    for (s = 0; s < 16; s++) begin
      phase = 4'($random(seed));
      stall = (s == 5);
      run({`CE_OPC_HUB, (s == 5) ? 3'h0 : 3'($random(seed)), s < 8, 4'hF, 9'($random(seed)),
        6'($random(seed)), 3'(s)}, 1'b0, 1'b0, s[1]);
      run({`CE_OPC_HUB, 4'hE, 4'h0, 18'($random(seed))}, 1'b0, 1'b0, 1'b0);
    end
    stall = 1'b0;
    results();
  end
  // Watchdog against a hung run
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    results();
  end
endmodule // tb_top
